// File: cutoff_pkg.sv
/*
 * Shared constants and types for the output force-cutoff unit.
 * Assumes a single 125 MHz system clock and an 8-bit register port.
 */
package cutoff_pkg;

    // ===========================================================
    // Register offsets
    localparam logic [3:0] ctrl_addr = 4'h0;
    localparam logic [3:0] edge_addr = 4'h1;
    localparam logic [3:0] status_addr = 4'h2;
    localparam logic [3:0] level0_addr = 4'h3;
    localparam logic [3:0] level1_addr = 4'h4;
    localparam logic [3:0] enable_addr = 4'h5;

    // ===========================================================
    // Control and status register fields
    localparam int ctl_source_lo = 0;
    localparam int ctl_source_hi = 1;
    localparam int ctl_polarity = 2;
    localparam int ctl_release_select = 3;
    localparam int ctl_timing = 4;
    localparam int ctl_glitch_guard = 5;
    localparam int ctl_release_request = 6;
    localparam int stat_source_flag = 0;
    localparam int stat_group0 = 1;
    localparam int stat_group1 = 2;

    // ===========================================================
    // Reset values
    localparam logic [7:0] ctrl_reset = 8'h00;
    localparam logic [1:0] edge_reset = 2'h0;
    localparam logic [7:0] level_reset = 8'h00;

    // ===========================================================
    // Encodings
    localparam logic [1:0] src_none = 2'h0;
    localparam logic [1:0] src_comparator = 2'h1;
    localparam logic [1:0] src_irq = 2'h2;
    localparam logic [1:0] src_event = 2'h3;
    localparam logic [1:0] lvl_off = 2'h0;
    localparam logic [1:0] lvl_hiz = 2'h1;
    localparam logic [1:0] lvl_low = 2'h2;
    localparam logic [1:0] lvl_high = 2'h3;
    localparam logic [1:0] edge_rise = 2'h0;
    localparam logic [1:0] edge_fall = 2'h1;
    localparam logic [1:0] edge_both = 2'h2;

    typedef enum logic [2:0] {
        mode_compare,
        mode_pwm,
        mode_pwm3,
        mode_reset_sync,
        mode_complementary
    } timer_mode_t;

    // Timer status arriving from the PWM timer
    typedef struct packed {
        logic running;
        logic sw_zero_write;
        logic period_match;
        logic overflow;
        logic [15:0] count;
    } counter_status_t;

    // Pin state: value and enable per group of four pins
    typedef struct packed {
        logic [3:0] value;
        logic [3:0] enable;
    } pin_group_t;

endpackage : cutoff_pkg

// File: output_cutoff_unit.sv
/*
 * Output force-cutoff unit between a two-channel PWM timer and its pins.
 * Assumes the timer supplies counter status, pin values and its own cutoff
 * selection, and that software follows the documented setup order.
 */
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
module output_cutoff_unit (
    input wire logic clock,
    input wire logic rst,
    input wire logic [3:0] address,
    input wire logic [7:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    output logic [7:0] read_data,
    input wire cutoff_pkg::timer_mode_t timer_mode,
    input wire cutoff_pkg::counter_status_t channel0_status,
    input wire cutoff_pkg::counter_status_t channel1_status,
    input wire logic comparator0_output,
    input wire logic external_irq_input,
    input wire logic event_link_trigger,
    input wire cutoff_pkg::pin_group_t timer_group0,
    input wire cutoff_pkg::pin_group_t timer_group1,
    input wire logic [7:0] timer_cutoff_level0,
    input wire logic [7:0] timer_cutoff_level1,
    output cutoff_pkg::pin_group_t pin_group0,
    output cutoff_pkg::pin_group_t pin_group1,
    output logic timer_pulse_cutoff
);
    import cutoff_pkg::*;

    // ===========================================================
    // Register state
    logic cutoff_unit_clock_enable;
    logic [7:0] cutoff_control_reg;
    logic [1:0] release_edge_select;
    logic [7:0] cutoff_level_select0;
    logic [7:0] cutoff_level_select1;
    logic source_out_of_range_flag;
    logic group0_cutoff_flag;
    logic group1_cutoff_flag;
    logic prev_source;
    logic prev_c0;
    pin_group_t delayed0;
    pin_group_t delayed1;
    counter_status_t prev0;
    counter_status_t prev1;

    wire [1:0] source_select = {cutoff_control_reg[ctl_source_hi], cutoff_control_reg[ctl_source_lo]};
    wire source_polarity = cutoff_control_reg[ctl_polarity];
    wire release_source_select = cutoff_control_reg[ctl_release_select];
    wire release_timing = cutoff_control_reg[ctl_timing];
    wire glitch_guard_enable = cutoff_control_reg[ctl_glitch_guard];
    wire release_request = cutoff_control_reg[ctl_release_request];

    // ===========================================================
    // Register decode
    // Either group held off counts as the unit being in cutoff
    wire cutoff_active = group0_cutoff_flag || group1_cutoff_flag;
    wire wr_ctrl = write_strobe && address == ctrl_addr && cutoff_unit_clock_enable;
    wire wr_edge = write_strobe && address == edge_addr && cutoff_unit_clock_enable && !cutoff_active;
    wire wr_lvl0 = write_strobe && address == level0_addr && cutoff_unit_clock_enable && !cutoff_active;
    wire wr_lvl1 = write_strobe && address == level1_addr && cutoff_unit_clock_enable && !cutoff_active;
    wire wr_en = write_strobe && address == enable_addr;
    wire select_written = wr_ctrl && write_data[1:0] != source_select;

    // ===========================================================
    // Source detection
    wire raw_source = (source_select == src_comparator) ? comparator0_output :
                      (source_select == src_irq) ? external_irq_input : 1'b0;
    wire level_source = raw_source ^ source_polarity;
    wire level_valid = source_select == src_comparator || source_select == src_irq;
    wire event_trigger = source_select == src_event && event_link_trigger;
    // Rising edge of detected level, never at select time, or an event-link trigger
    wire trigger = cutoff_unit_clock_enable &&
                   ((level_valid && level_source && !prev_source && !select_written) ||
                    event_trigger);

    // ===========================================================
    // Release events from the timer
    function automatic logic zero_event(input counter_status_t now, input counter_status_t was,
                                        input logic compare_mode);
        // Counter newly at zero while running; not at start, not at stop
        zero_event = now.running && was.running && now.count == 16'h0000 &&
                     (now.sw_zero_write || now.period_match ||
                      (compare_mode && now.overflow));
    endfunction : zero_event

    wire compare_mode = timer_mode == mode_compare;
    wire zero0 = zero_event(channel0_status, prev0, compare_mode);
    wire zero1 = zero_event(channel1_status, prev1, compare_mode);
    wire c0_now = timer_group0.value[2];
    wire c0_rise = c0_now && !prev_c0;
    wire c0_fall = !c0_now && prev_c0;
    wire edge_hit = (release_edge_select == edge_rise && c0_rise) ||
                    (release_edge_select == edge_fall && c0_fall) ||
                    (release_edge_select == edge_both && (c0_rise || c0_fall));

    logic rel0_event;
    logic rel1_event;
    always_comb begin
        unique case (timer_mode)
            mode_reset_sync: begin
                rel0_event = zero0;
                rel1_event = zero0;
            end
            mode_complementary: begin
                rel0_event = edge_hit;
                rel1_event = edge_hit;
            end
            default: begin
                rel0_event = zero0;
                rel1_event = zero1;
            end
        endcase
    end

    // Hardware path needs no request; software path waits for it
    wire armed = release_source_select ? release_request : 1'b1;
    wire immediate = release_source_select && !release_timing && release_request;
    wire hw_allowed = !release_source_select && source_select != src_event;
    wire release0 = group0_cutoff_flag && (immediate ||
                    ((release_timing || hw_allowed) && armed && rel0_event));
    wire release1 = group1_cutoff_flag && (immediate ||
                    ((release_timing || hw_allowed) && armed && rel1_event));
    wire next_g0 = trigger || (group0_cutoff_flag && !release0);
    wire next_g1 = trigger || (group1_cutoff_flag && !release1);
    wire request_done = release_request && cutoff_active && !next_g0 && !next_g1;

    // ===========================================================
    // Registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cutoff_unit_clock_enable <= 1'b0;
            cutoff_control_reg <= ctrl_reset;
            release_edge_select <= edge_reset;
            cutoff_level_select0 <= level_reset;
            cutoff_level_select1 <= level_reset;
        end else begin
            if (wr_en)
                cutoff_unit_clock_enable <= write_data[0];
            if (wr_ctrl)
                // Request only sets while cutoff holds
                cutoff_control_reg <= {1'b0, write_data[ctl_release_request] && cutoff_active,
                                       write_data[5:0]};
            else if (request_done || !cutoff_active)
                cutoff_control_reg[ctl_release_request] <= 1'b0;
            if (wr_edge)
                release_edge_select <= write_data[1:0];
            if (wr_lvl0)
                cutoff_level_select0 <= write_data;
            if (wr_lvl1)
                cutoff_level_select1 <= write_data;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            source_out_of_range_flag <= 1'b0;
            group0_cutoff_flag <= 1'b0;
            group1_cutoff_flag <= 1'b0;
            prev_source <= 1'b0;
            prev_c0 <= 1'b0;
            prev0 <= '0;
            prev1 <= '0;
            delayed0 <= '0;
            delayed1 <= '0;
        end else begin
            // Set level wins; clears on undetected level
            source_out_of_range_flag <= level_valid && level_source && cutoff_unit_clock_enable;
            group0_cutoff_flag <= next_g0;
            group1_cutoff_flag <= next_g1;
            // New selection counts as already seen: no edge next cycle
            prev_source <= select_written || (level_valid && level_source);
            prev_c0 <= c0_now;
            prev0 <= channel0_status;
            prev1 <= channel1_status;
            delayed0 <= timer_group0;
            delayed1 <= timer_group1;
        end
    end

    // ===========================================================
    // Pin priority
    function automatic pin_group_t apply_level(input pin_group_t timer_pins, input logic [7:0] unit_lvl,
                                               input logic [7:0] timer_lvl, input logic cut);
        logic [1:0] sel;
        apply_level = timer_pins;
        for (int i = 0; i < 4; i++) begin
            sel = (cut && unit_lvl[2*i +: 2] != lvl_off) ? unit_lvl[2*i +: 2] : timer_lvl[2*i +: 2];
            unique case (sel)
                lvl_hiz: apply_level.enable[i] = 1'b0;
                lvl_low: begin
                    apply_level.enable[i] = 1'b1;
                    apply_level.value[i] = 1'b0;
                end
                lvl_high: begin
                    apply_level.enable[i] = 1'b1;
                    apply_level.value[i] = 1'b1;
                end
                lvl_off: apply_level.enable[i] = timer_pins.enable[i];
            endcase
        end
    endfunction : apply_level

    wire pin_group_t path0 = glitch_guard_enable ? delayed0 : timer_group0;
    wire pin_group_t path1 = glitch_guard_enable ? delayed1 : timer_group1;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_group0 <= '0;
            pin_group1 <= '0;
            read_data <= 8'h00;
        end else begin
            pin_group0 <= apply_level(path0, cutoff_level_select0, timer_cutoff_level0,
                                      group0_cutoff_flag);
            pin_group1 <= apply_level(path1, cutoff_level_select1, timer_cutoff_level1,
                                      group1_cutoff_flag);
            read_data <= 8'h00;
            if (read_strobe) begin
                unique case (address)
                    ctrl_addr: read_data <= cutoff_control_reg;
                    edge_addr: read_data <= {6'h00, release_edge_select};
                    status_addr: read_data <= {5'h00, group1_cutoff_flag, group0_cutoff_flag,
                                               source_out_of_range_flag};
                    level0_addr: read_data <= cutoff_level_select0;
                    level1_addr: read_data <= cutoff_level_select1;
                    enable_addr: read_data <= {7'h00, cutoff_unit_clock_enable};
                    default: read_data <= 8'h00;
                endcase
            end
        end
    end

    assign timer_pulse_cutoff = timer_mode == mode_complementary && cutoff_active;

    // ===========================================================
    // Checks
    a_trigger_enters_cutoff: assert property (@(posedge clock) disable iff (rst)
        trigger |=> group0_cutoff_flag && group1_cutoff_flag) else $error("cutoff not entered");
    a_immediate_release: assert property (@(posedge clock) disable iff (rst)
        immediate && !trigger |=> !group0_cutoff_flag) else $error("no immediate release");
    a_request_autoclear: assert property (@(posedge clock) disable iff (rst)
        $fell(cutoff_active) |-> !release_request) else $error("request not cleared");
    a_reset_sync_release: assert property (@(posedge clock) disable iff (rst)
        timer_mode == mode_reset_sync && group1_cutoff_flag && zero0 && armed && hw_allowed && !trigger
        |=> !group1_cutoff_flag) else $error("reset sync release missed");
    a_start_no_release: assert property (@(posedge clock) disable iff (rst)
        !prev0.running |-> !zero0) else $error("start treated as release");
    a_stop_no_release: assert property (@(posedge clock) disable iff (rst)
        !channel0_status.running |-> !zero0) else $error("stop treated as release");
    a_flag_tracks_level: assert property (@(posedge clock) disable iff (rst)
        cutoff_unit_clock_enable && level_valid && !level_source |=> !source_out_of_range_flag)
        else $error("source flag stuck");
    a_select_no_cutoff: assert property (@(posedge clock) disable iff (rst)
        select_written && !cutoff_active && !event_trigger && write_data[1:0] != src_event
        |=> !group0_cutoff_flag ##1 !group0_cutoff_flag) else $error("select caused cutoff");
    a_idle_request_ignored: assert property (@(posedge clock) disable iff (rst)
        !cutoff_active |=> !release_request) else $error("idle request kept");
    a_complementary_pulse: assert property (@(posedge clock) disable iff (rst)
        timer_mode == mode_complementary && group0_cutoff_flag |-> timer_pulse_cutoff)
        else $error("pulse cutoff missing");
    a_edge_release_only: assert property (@(posedge clock) disable iff (rst)
        timer_mode == mode_complementary && group0_cutoff_flag && !edge_hit && !immediate
        |=> group0_cutoff_flag) else $error("released without edge");

    c_cutoff_entered: cover property (@(posedge clock) disable iff (rst) $rose(group0_cutoff_flag));
    c_sw_release: cover property (@(posedge clock) disable iff (rst) immediate ##1 !cutoff_active);
    c_edge_release: cover property (@(posedge clock) disable iff (rst)
        timer_mode == mode_complementary && release0);
    c_channel_split: cover property (@(posedge clock) disable iff (rst)
        group1_cutoff_flag && !group0_cutoff_flag);
    c_select_preset: cover property (@(posedge clock) disable iff (rst)
        select_written && !cutoff_active ##2 source_out_of_range_flag);

endmodule : output_cutoff_unit

// File: timer_model.sv
/*
 * Behavioural model of the two-channel PWM timer seen by the cutoff unit.
 * Assumes the bench calls its tasks; every change lands just after a rising edge.
 */
`timescale 1ns/1ps
module timer_model (
    input wire logic clock,
    output cutoff_pkg::counter_status_t channel0_status,
    output cutoff_pkg::counter_status_t channel1_status,
    output cutoff_pkg::pin_group_t timer_group0,
    output cutoff_pkg::pin_group_t timer_group1
);
    import cutoff_pkg::*;
    localparam counter_status_t counting = '{running: 1'b1, sw_zero_write: 1'b0, period_match: 1'b0,
        overflow: 1'b0, count: 16'h0001};

    initial begin
        channel0_status = counting;
        channel1_status = counting;
        timer_group0 = '{value: 4'h0, enable: 4'hf};
        timer_group1 = '{value: 4'h0, enable: 4'hf};
    end

    task automatic put(input logic ch, input counter_status_t s);
        if (ch) channel1_status <= s;
        else channel0_status <= s;
    endtask : put

    // ===========================================================
    // Counter reaching zero with the given cause flags
    task automatic zero_event(input logic ch, input logic [2:0] kind, input logic run_now, input logic run_before);
        counter_status_t s;
        s = '{running: run_before, sw_zero_write: 1'b0, period_match: 1'b0, overflow: 1'b0,
            count: run_before ? 16'hffff : 16'h0000};
        @(posedge clock);
        put(ch, s);
        s = '{running: run_now, sw_zero_write: kind[2], period_match: kind[1], overflow: kind[0],
            count: 16'h0000};
        @(posedge clock);
        put(ch, s);
        @(posedge clock);
        put(ch, counting);
    endtask : zero_event

    task automatic set_c0(input logic v);
        @(posedge clock);
        timer_group0.value[2] <= v;
        repeat (3) @(posedge clock);
    endtask : set_c0
endmodule : timer_model

// File: tb.sv
/*
 * Self-checking bench for output_cutoff_unit, driven through its register port.
 * Assumes cutoff_pkg, the design and timer_model are compiled before it.
 */
`timescale 1ns/1ps
module tb;
    import cutoff_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [3:0] address = 4'h0;
    logic [7:0] write_data = 8'h00;
    logic write_strobe = 1'b0;
    logic read_strobe = 1'b0;
    logic [7:0] read_data;
    timer_mode_t timer_mode = mode_compare;
    counter_status_t channel0_status, channel1_status;
    logic comparator0_output = 1'b0;
    logic external_irq_input = 1'b1;
    logic event_link_trigger = 1'b0;
    logic [7:0] timer_cutoff_level0 = 8'h00;
    pin_group_t timer_group0, timer_group1, pin_group0, pin_group1;
    logic timer_pulse_cutoff;
    int err_total = 0;
    int check_count = 0;

    always #4 clock = ~clock;

    output_cutoff_unit output_cutoff_unit_i (.clock(clock), .rst(rst), .address(address),
        .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
        .read_data(read_data), .timer_mode(timer_mode), .channel0_status(channel0_status),
        .channel1_status(channel1_status), .comparator0_output(comparator0_output),
        .external_irq_input(external_irq_input), .event_link_trigger(event_link_trigger),
        .timer_group0(timer_group0), .timer_group1(timer_group1), .timer_cutoff_level0(timer_cutoff_level0),
        .timer_cutoff_level1(8'h00), .pin_group0(pin_group0), .pin_group1(pin_group1),
        .timer_pulse_cutoff(timer_pulse_cutoff));

    timer_model timer_model_i (.clock(clock), .channel0_status(channel0_status),
        .channel1_status(channel1_status), .timer_group0(timer_group0), .timer_group1(timer_group1));

    // ===========================================================
    // Access and compare tasks
    task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] seen);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check8

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1;
        check8("read_data", exp, read_data);
    endtask : rd

    // Masked value and enable of both pin groups
    task automatic pins(input logic [7:0] e0, input logic [7:0] e1);
        @(posedge clock);
        #1;
        check8("pin_group0", e0, {pin_group0.value & pin_group0.enable, pin_group0.enable});
        check8("pin_group1", e1, {pin_group1.value & pin_group1.enable, pin_group1.enable});
    endtask : pins

    // Comparator pulse held two cycles
    task automatic trig;
        @(posedge clock);
        comparator0_output <= 1'b1;
        repeat (2) @(posedge clock);
        comparator0_output <= 1'b0;
        repeat (2) @(posedge clock);
    endtask : trig

    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        wrap_up();
    end

    // ===========================================================
    // Test sequence
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) rd(i[3:0], 8'h00);
        wr(ctrl_addr, 8'h09);
        rd(ctrl_addr, 8'h00);
        wr(enable_addr, 8'h01);
        wr(ctrl_addr, 8'h09);
        wr(edge_addr, {6'h00, edge_fall});
        wr(level0_addr, 8'h39);
        wr(level1_addr, 8'hff);
        rd(ctrl_addr, 8'h09);
        @(posedge clock);
        comparator0_output <= 1'b1;
        repeat (3) @(posedge clock);
        rd(status_addr, 8'h07);
        pins(8'h4e, 8'hff);
        wr(level0_addr, 8'h00);
        rd(level0_addr, 8'h39);
        comparator0_output <= 1'b0;
        rd(status_addr, 8'h06);
        wr(ctrl_addr, 8'h49);
        rd(status_addr, 8'h00);
        rd(ctrl_addr, 8'h09);
        pins(8'h0f, 8'h0f);
        wr(ctrl_addr, 8'h49);
        rd(ctrl_addr, 8'h09);
        rd(status_addr, 8'h00);
        // Already detected when selected
        wr(ctrl_addr, 8'h08);
        comparator0_output <= 1'b1;
        wr(ctrl_addr, 8'h09);
        rd(status_addr, 8'h01);
        comparator0_output <= 1'b0;
        // Low-active irq source, comparator unselected
        wr(ctrl_addr, 8'h0e);
        trig();
        rd(status_addr, 8'h00);
        external_irq_input <= 1'b0;
        rd(status_addr, 8'h07);
        external_irq_input <= 1'b1;
        wr(ctrl_addr, 8'h4e);
        rd(status_addr, 8'h00);
        // Hardware release, compare mode
        wr(ctrl_addr, 8'h01);
        trig();
        timer_model_i.zero_event(1'b0, 3'b010, 1'b1, 1'b0);
        rd(status_addr, 8'h06);
        timer_model_i.zero_event(1'b0, 3'b001, 1'b1, 1'b1);
        rd(status_addr, 8'h04);
        timer_model_i.zero_event(1'b1, 3'b010, 1'b0, 1'b1);
        rd(status_addr, 8'h04);
        timer_model_i.zero_event(1'b1, 3'b100, 1'b1, 1'b1);
        rd(status_addr, 8'h00);
        // PWM mode ignores overflow
        timer_mode <= mode_pwm;
        trig();
        timer_model_i.zero_event(1'b0, 3'b001, 1'b1, 1'b1);
        rd(status_addr, 8'h06);
        timer_model_i.zero_event(1'b0, 3'b010, 1'b1, 1'b1);
        rd(status_addr, 8'h04);
        timer_model_i.zero_event(1'b1, 3'b100, 1'b1, 1'b1);
        rd(status_addr, 8'h00);
        // Reset-synchronous mode
        timer_mode <= mode_reset_sync;
        trig();
        timer_model_i.zero_event(1'b1, 3'b010, 1'b1, 1'b1);
        rd(status_addr, 8'h06);
        timer_model_i.zero_event(1'b0, 3'b010, 1'b1, 1'b1);
        rd(status_addr, 8'h00);
        // Deferred software release
        timer_mode <= mode_compare;
        wr(ctrl_addr, 8'h19);
        trig();
        timer_model_i.zero_event(1'b0, 3'b010, 1'b1, 1'b1);
        rd(status_addr, 8'h06);
        wr(ctrl_addr, 8'h59);
        rd(status_addr, 8'h06);
        timer_model_i.zero_event(1'b0, 3'b100, 1'b1, 1'b1);
        rd(status_addr, 8'h04);
        timer_model_i.zero_event(1'b1, 3'b100, 1'b1, 1'b1);
        rd(status_addr, 8'h00);
        rd(ctrl_addr, 8'h19);
        // Complementary mode, falling C0 edge selected
        timer_mode <= mode_complementary;
        wr(ctrl_addr, 8'h01);
        trig();
        pins(8'h4e, 8'hff);
        // Timer asks high on pins 0 and 3: unit Hi-Z wins on 0, timer applies on 3
        timer_cutoff_level0 <= 8'hc3;
        pins(8'hce, 8'hff);
        timer_cutoff_level0 <= 8'h00;
        check8("timer_pulse_cutoff", 8'h01, {7'h00, timer_pulse_cutoff});
        timer_model_i.set_c0(1'b1);
        rd(status_addr, 8'h06);
        timer_model_i.set_c0(1'b0);
        rd(status_addr, 8'h00);
        check8("timer_pulse_cutoff", 8'h00, {7'h00, timer_pulse_cutoff});
        // Event source needs software release
        timer_mode <= mode_compare;
        wr(ctrl_addr, 8'h03);
        @(posedge clock);
        event_link_trigger <= 1'b1;
        @(posedge clock);
        event_link_trigger <= 1'b0;
        rd(status_addr, 8'h06);
        timer_model_i.zero_event(1'b0, 3'b100, 1'b1, 1'b1);
        rd(status_addr, 8'h06);
        wr(ctrl_addr, 8'h0b);
        wr(ctrl_addr, 8'h4b);
        rd(status_addr, 8'h00);
        // Glitch guard: timer C0 change reaches the pin one clock later
        wr(ctrl_addr, 8'h20);
        fork
            timer_model_i.set_c0(1'b1);
            begin
                @(posedge clock);
                pins(8'h0f, 8'h0f);
                pins(8'h4f, 8'h0f);
            end
        join
        wrap_up();
    end
endmodule : tb
